/* rrb_builder.sv */
`timescale 1ns/1ps
module rrb_builder #(
    parameter int MAX_ENTRIES = 8,
    parameter int FIFO_DEPTH  = 16
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // register port
    input  wire logic [11:0]       regAddr,
    input  wire logic [31:0]       regWrData,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic [31:0]            regRdData,
    // reservation command completions
    input  wire rrb_pkg::rrb_evt_t resvEvent,
    // report command
    input  wire logic              cmdValid,
    output logic                   cmdReady,
    input  wire rrb_pkg::rrb_cmd_t cmd,
    // transfer descriptor
    output logic                   descValid,
    input  wire logic              descReady,
    output rrb_pkg::rrb_desc_t     desc,
    // status data stream
    output logic                   dataValid,
    input  wire logic              dataReady,
    output rrb_pkg::rrb_data_t     dataOut,
    // completion
    output logic                   cplValid,
    input  wire logic              cplReady,
    output rrb_pkg::rrb_cpl_t      cpl
);
    localparam int EB = $clog2(MAX_ENTRIES);

    initial
    begin
        if (MAX_ENTRIES < 2 || (1 << EB) != MAX_ENTRIES || MAX_ENTRIES > 64)
            $error("entry count must be a power of two from 2 to 64");
    end

    typedef enum logic [2:0] {ST_IDLE, ST_DESC, ST_STREAM, ST_DRAIN, ST_CPL} rrb_state_t;

    rrb_state_t  state_reg;
    logic [15:0] ctrl_reg;
    logic [15:0] regCount_reg;
    logic [31:0] counter_reg;
    logic [15:0] cmdCount_reg;
    logic [31:0] snapCounter_reg;
    logic [7:0]  snapKind_reg;
    logic [7:0]  snapPersist_reg;
    logic [15:0] snapCount_reg;
    logic [32:0] xferLen_reg;
    logic [32:0] idx_reg;
    logic [EB-1:0] entry_reg;
    logic [2:0]  word_reg;
    logic [31:0] rdData_reg;
    rrb_pkg::rrb_desc_t desc_reg;
    logic [15:0] cmdId_reg;

    // register decode
    wire        inEntries = regAddr >= rrb_pkg::OFF_ENTRIES;
    wire [11:0] entOff    = regAddr - rrb_pkg::OFF_ENTRIES;
    wire [6:0]  busEntWide = entOff[11:rrb_pkg::ENTRY_STRIDE_LOG2];
    wire [2:0]  busWord   = entOff[4:2];
    wire        entHit    = inEntries && busWord < 3'(rrb_pkg::ENTRY_DWORDS)
                          && busEntWide < 7'(MAX_ENTRIES);
    wire        selCtrl   = regAddr == rrb_pkg::OFF_CTRL;
    wire        selCount  = regAddr == rrb_pkg::OFF_REGCOUNT;
    wire        selCntr   = regAddr == rrb_pkg::OFF_COUNTER;
    wire        selStat   = regAddr == rrb_pkg::OFF_STATUS;
    wire [31:0] busEntData;
    wire [31:0] rdMux = selCtrl  ? {16'h0000, ctrl_reg}
                      : selCount ? {16'h0000, regCount_reg}
                      : selCntr  ? counter_reg
                      : selStat  ? {15'h0000, state_reg != ST_IDLE, cmdCount_reg}
                      : entHit   ? busEntData : 32'h0000_0000;
    // registrant count cannot exceed the table
    wire [15:0] countWr = (regWrData[15:0] > 16'(MAX_ENTRIES)) ? 16'(MAX_ENTRIES)
                                                               : regWrData[15:0];

    // change counter steps, one per qualifying completion
    wire        stepReg = resvEvent.registerDone;
    wire        stepRel = resvEvent.releaseDone
                        && resvEvent.releaseAction == rrb_pkg::RELEASE_CLEAR;
    wire        stepAcq = resvEvent.acquireDone
                        && (resvEvent.acquireAction == rrb_pkg::ACQUIRE_PREEMPT
                        ||  resvEvent.acquireAction == rrb_pkg::ACQUIRE_PRE_ABRT);
    wire [31:0] counterStep = {30'h0000_0000, 2'(stepReg) + 2'(stepRel) + 2'(stepAcq)};

    // transfer length: zero-based count, clipped to the structure size
    wire [32:0] totalDwords = 33'(rrb_pkg::HDR_DWORDS)
                            + 33'(rrb_pkg::ENTRY_DWORDS) * {17'h00000, regCount_reg};
    wire [32:0] reqDwords   = {1'b0, cmd.dwordCountField} + 33'h1;
    wire [32:0] xferLenNext = (reqDwords < totalDwords) ? reqDwords : totalDwords;

    // structure words in ascending order, little-endian bytes
    wire        inHeader = idx_reg < 33'(rrb_pkg::HDR_DWORDS);
    wire [31:0] entWord;
    wire [31:0] hdrWord = (idx_reg == 33'h0) ? snapCounter_reg
                        : (idx_reg == 33'h1) ? {8'h00, snapCount_reg, snapKind_reg}
                        : (idx_reg == 33'h2) ? {16'h0000, snapPersist_reg, 8'h00}
                        : 32'h0000_0000;
    wire        isLast  = idx_reg == xferLen_reg - 33'h1;
    wire        fifoInReady;
    wire        fifoOutValid;
    wire        push    = state_reg == ST_STREAM && fifoInReady;
    rrb_pkg::rrb_data_t pushData;
    assign pushData.data = inHeader ? hdrWord : entWord;
    assign pushData.last = isLast;

    // handshakes
    assign cmdReady  = state_reg == ST_IDLE;
    assign descValid = state_reg == ST_DESC;
    assign cplValid  = state_reg == ST_CPL;
    assign desc      = desc_reg;
    assign dataValid = fifoOutValid;
    assign regRdData = rdData_reg;
    assign cpl.cmdId  = cmdId_reg;
    assign cpl.status = rrb_pkg::STATUS_SUCCESS;

    rrb_entry_table #(
        .ENTRIES (MAX_ENTRIES)
    ) u_table (
        .clock    (clock),
        .wrEnable (regWrite && entHit),
        .wrEntry  (busEntWide[EB-1:0]),
        .wrWord   (busWord),
        .wrData   (regWrData),
        .busEntry (busEntWide[EB-1:0]),
        .busWord  (busWord),
        .busData  (busEntData),
        .strEntry (entry_reg),
        .strWord  (word_reg),
        .strData  (entWord)
    );

    rrb_fifo #(
        .WIDTH ($bits(rrb_pkg::rrb_data_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .resetn   (resetn),
        .inValid  (state_reg == ST_STREAM),
        .inReady  (fifoInReady),
        .inData   (pushData),
        .outValid (fifoOutValid),
        .outReady (dataReady),
        .outData  (dataOut)
    );

    // software registers and the per-namespace change counter
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            ctrl_reg     <= rrb_pkg::CTRL_RESET;
            regCount_reg <= rrb_pkg::REGCOUNT_RESET;
            counter_reg  <= rrb_pkg::COUNTER_RESET;
            rdData_reg   <= 32'h0000_0000;
        end
        else
        begin
            if (regWrite && selCtrl)  ctrl_reg <= regWrData[15:0];
            if (regWrite && selCount) regCount_reg <= countWr;
            counter_reg <= counter_reg + counterStep;
            rdData_reg  <= regRead ? rdMux : 32'h0000_0000;
        end
    end

    // command sequencer
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            state_reg    <= ST_IDLE;
            cmdCount_reg <= 16'h0000;
            idx_reg      <= 33'h0;
            entry_reg    <= '0;
            word_reg     <= 3'h0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:   if (cmdValid) state_reg <= ST_DESC;
                ST_DESC:   if (descReady) state_reg <= ST_STREAM;
                ST_STREAM: if (push && isLast) state_reg <= ST_DRAIN;
                ST_DRAIN:  if (!fifoOutValid) state_reg <= ST_CPL;
                ST_CPL:
                begin
                    if (cplReady)
                    begin
                        state_reg    <= ST_IDLE;
                        cmdCount_reg <= cmdCount_reg + 16'h1;
                    end
                end
            endcase
            if (state_reg == ST_IDLE)
            begin
                idx_reg   <= 33'h0;
                entry_reg <= '0;
                word_reg  <= 3'h0;
            end
            else if (push)
            begin
                idx_reg <= idx_reg + 33'h1;
                if (!inHeader)
                begin
                    word_reg  <= (word_reg == 3'(rrb_pkg::ENTRY_DWORDS - 1)) ? 3'h0
                                                                              : word_reg + 3'h1;
                    if (word_reg == 3'(rrb_pkg::ENTRY_DWORDS - 1)) entry_reg <= entry_reg + 1'b1;
                end
            end
        end
    end

    // snapshot header fields and length at acceptance; entry words are read from the table while streaming
    always_ff @(posedge clock)
    begin
        if (cmdValid && cmdReady)
        begin
            snapCounter_reg        <= counter_reg;
            snapKind_reg           <= ctrl_reg[rrb_pkg::CTRL_KIND_LSB +: 8];
            snapPersist_reg        <= ctrl_reg[rrb_pkg::CTRL_PERSIST_LSB +: 8];
            snapCount_reg          <= regCount_reg;
            xferLen_reg            <= xferLenNext;
            desc_reg.dwordLen      <= xferLenNext;
            desc_reg.bufferPointer <= cmd.bufferPointer;
            cmdId_reg              <= cmd.cmdId;
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    wire accept = cmdValid && cmdReady;

    len_clip_a: assert property (accept |=> desc.dwordLen == $past(xferLenNext)
        && desc.dwordLen <= $past(reqDwords) && desc.dwordLen <= $past(totalDwords))
        else $error("transfer length not clipped");
    no_overrun_a: assert property (push |-> idx_reg < xferLen_reg)
        else $error("word pushed past the transfer length");
    last_mark_a: assert property (push && pushData.last |=> state_reg == ST_DRAIN)
        else $error("last word did not end streaming");
    first_word_a: assert property (push && idx_reg == 33'h0
        |-> pushData.data == snapCounter_reg) else $error("first word is not counter");
    reg_step_a: assert property (stepReg && !stepRel && !stepAcq
        |=> counter_reg == $past(counter_reg) + 32'h1) else $error("register missed");
    rel_step_a: assert property (resvEvent.releaseDone && !stepRel && !stepReg
        && !stepAcq |=> counter_reg == $past(counter_reg)) else $error("release miscounted");
    acq_step_a: assert property (stepAcq && stepRel && !stepReg
        |=> counter_reg == $past(counter_reg) + 32'h2) else $error("acquire missed");
    kind_byte_a: assert property (push && idx_reg == 33'h1
        |-> pushData.data[7:0] == snapKind_reg) else $error("kind byte wrong");
    count_bytes_a: assert property (push && idx_reg == 33'h1
        |-> pushData.data[31:8] == {8'h00, snapCount_reg}) else $error("count bytes wrong");
    persist_byte_a: assert property (push && idx_reg == 33'h2
        |-> pushData.data == {16'h0000, snapPersist_reg, 8'h00}) else $error("persist wrong");
    cpl_order_a: assert property (state_reg == ST_DRAIN && !fifoOutValid
        |=> cplValid && !dataValid) else $error("completion not posted after data");

    short_rep_c: cover property (accept && reqDwords < totalDwords);
    long_rep_c:  cover property (accept && reqDwords > totalDwords && regCount_reg != 16'h0);
    stall_c:     cover property (state_reg == ST_STREAM && !fifoInReady);
    done_c:      cover property (cplValid && cplReady);
endmodule

/* rrb_entry_table.sv */
`timescale 1ns/1ps
module rrb_entry_table #(
    parameter int ENTRIES = 8
) (
    // clock
    input  wire logic                       clock,
    // write port
    input  wire logic                       wrEnable,
    input  wire logic [$clog2(ENTRIES)-1:0] wrEntry,
    input  wire logic [2:0]                 wrWord,
    input  wire logic [31:0]                wrData,
    // bus read port
    input  wire logic [$clog2(ENTRIES)-1:0] busEntry,
    input  wire logic [2:0]                 busWord,
    output logic [31:0]                     busData,
    // stream read port
    input  wire logic [$clog2(ENTRIES)-1:0] strEntry,
    input  wire logic [2:0]                 strWord,
    output logic [31:0]                     strData
);
    localparam int EW = rrb_pkg::ENTRY_DWORDS;

    logic [31:0] mem [ENTRIES][EW];
    logic [31:0] wrMasked;

    // word 0: controller id plus holder flag only; word 1 is reserved
    assign wrMasked = (wrWord == 3'h0) ? (wrData & 32'h0001_ffff)
                    : (wrWord == 3'h1) ? 32'h0000_0000 : wrData;
    assign busData  = mem[busEntry][busWord];
    assign strData  = mem[strEntry][strWord];

    // storage, cleared so unwritten entries report zeros
    always_ff @(posedge clock)
    begin
        if (wrEnable) mem[wrEntry][wrWord] <= wrMasked;
    end

    initial
    begin
        for (int e = 0; e < ENTRIES; e++)
            for (int w = 0; w < EW; w++)
                mem[e][w] = 32'h0000_0000;
    end
endmodule

/* rrb_fifo.sv */
`timescale 1ns/1ps
module rrb_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // filling side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // draining side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_reg;
    logic [AW:0]      rdPtr_reg;
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;

    // full when pointers differ only in the wrap bit
    assign inReady  = (wrPtr_reg ^ rdPtr_reg) != {1'b1, {AW{1'b0}}};
    assign outValid = wrPtr_reg != rdPtr_reg;
    assign outData  = mem[rdPtr_reg[AW-1:0]];

    // pointers
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end
        else
        begin
            if (doPush) wrPtr_reg <= wrPtr_reg + 1'b1;
            if (doPop)  rdPtr_reg <= rdPtr_reg + 1'b1;
        end
    end

    // storage
    always_ff @(posedge clock)
    begin
        if (doPush) mem[wrPtr_reg[AW-1:0]] <= inData;
    end
endmodule

/* rrb_host_model.sv */
`timescale 1ns/1ps
module rrb_host_model (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               resetn,
    // pacing and record clear
    input  wire logic               slow,
    input  wire logic               clear,
    // descriptor channel
    input  wire logic               descValid,
    output logic                    descReady,
    input  wire rrb_pkg::rrb_desc_t desc,
    // data channel
    input  wire logic               dataValid,
    output logic                    dataReady,
    input  wire rrb_pkg::rrb_data_t dataOut,
    // completion channel
    input  wire logic               cplValid,
    output logic                    cplReady,
    input  wire rrb_pkg::rrb_cpl_t  cpl
);
    logic [31:0]        words [0:63];
    int                 nWords;
    int                 lastAt;
    int                 cplSeen;
    int                 wordsAtCpl;
    rrb_pkg::rrb_desc_t descSeen;
    rrb_pkg::rrb_cpl_t  cplGot;
    logic [3:0]         phase;

    // a slow host takes each channel on one cycle in four, at different phases
    assign descReady = !slow || (phase[1:0] == 2'h1);
    assign dataReady = !slow || (phase[1:0] == 2'h2);
    assign cplReady  = !slow || (phase[1:0] == 2'h3);

    // records what the host buffer and completion queue receive
    always_ff @(posedge clock)
    begin
        phase <= resetn ? phase + 4'h1 : 4'h0;
        if (clear)
        begin
            nWords     <= 0;
            lastAt     <= -1;
            cplSeen    <= 0;
            wordsAtCpl <= -1;
            descSeen   <= '0;
        end
        else
        begin
            if (descValid && descReady)
                descSeen <= desc;
            if (dataValid && dataReady && nWords < 64)
            begin
                words[nWords] <= dataOut.data;
                nWords        <= nWords + 1;
                if (dataOut.last)
                    lastAt <= nWords;
            end
            if (cplValid && cplReady)
            begin
                cplGot     <= cpl;
                cplSeen    <= cplSeen + 1;
                wordsAtCpl <= nWords;
            end
        end
    end
endmodule

/* rrb_pkg.sv */
// How it works
// - The host puts a 32-bit dword count in command dword 10 and the block sends at most that value plus one dwords.
// - A request shorter than the status structure sends only the leading part of it.
// - A request longer than the structure sends the whole structure and nothing after it.
// - Bytes 3 to 0 hold a 32-bit change counter for the namespace that wraps to zero.
// - The change counter steps on every successful register command on the namespace.
// - The change counter steps on every successful release command whose release action is clear.
// - The change counter steps on every successful acquire with action preempt or preempt-and-abort.
// - Byte 4 is zero with no reservation held, otherwise the code of the reservation kind held.
// - Bytes 6 to 5 give the registrant count, equal to the number of entries, and bytes 8 to 7 are zero.
// - The structure holds exactly one per-controller entry for each registrant controller; it sends regCount_reg entries, at most MAX_ENTRIES.
// - Byte 9 gives the power-loss persist state, where zero means cleared at power on.
// - Only dword 10, the data pointer and the command id, which the completion carries back, are used; all other command fields are ignored.
// - The status data go to the host buffer given by the 128-bit data pointer.
// - A persist state of one means reservations and registrants survive power loss.
// - Entries start at byte 24, 24 bytes each: controller id, holder flag, host id and key.
// - When the command ends, a completion carrying its status is posted.
package rrb_pkg;
    // structure layout, in dwords
    localparam int HDR_DWORDS   = 6;
    localparam int ENTRY_DWORDS = 6;

    // register offsets on the register port
    localparam logic [11:0] OFF_CTRL     = 12'h000;
    localparam logic [11:0] OFF_REGCOUNT = 12'h004;
    localparam logic [11:0] OFF_COUNTER  = 12'h008;
    localparam logic [11:0] OFF_STATUS   = 12'h00c;
    localparam logic [11:0] OFF_ENTRIES  = 12'h100;
    localparam int          ENTRY_STRIDE_LOG2 = 5;

    // field positions
    localparam int CTRL_KIND_LSB    = 0;
    localparam int CTRL_PERSIST_LSB = 8;
    localparam int STATUS_BUSY_BIT  = 16;
    localparam int HOLDER_BIT       = 16;

    // reset values
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [15:0] REGCOUNT_RESET = 16'h0000;
    localparam logic [31:0] COUNTER_RESET  = 32'h0000_0000;

    // action encodings that move the change counter
    localparam logic [2:0] RELEASE_CLEAR    = 3'h1;
    localparam logic [2:0] ACQUIRE_PREEMPT  = 3'h1;
    localparam logic [2:0] ACQUIRE_PRE_ABRT = 3'h2;

    // persist states and completion status
    localparam logic [7:0]  PERSIST_CLEARED = 8'h00;
    localparam logic [7:0]  PERSIST_KEPT    = 8'h01;
    localparam logic [15:0] STATUS_SUCCESS  = 16'h0000;

    typedef struct packed {
        logic [15:0]  cmdId;
        logic [31:0]  dwordCountField;
        logic [127:0] bufferPointer;
    } rrb_cmd_t;

    typedef struct packed {
        logic [127:0] bufferPointer;
        logic [32:0]  dwordLen;
    } rrb_desc_t;

    typedef struct packed {
        logic [31:0] data;
        logic        last;
    } rrb_data_t;

    typedef struct packed {
        logic [15:0] cmdId;
        logic [15:0] status;
    } rrb_cpl_t;

    typedef struct packed {
        logic       registerDone;
        logic       releaseDone;
        logic [2:0] releaseAction;
        logic       acquireDone;
        logic [2:0] acquireAction;
    } rrb_evt_t;
endpackage

/* test_reservation_report_builder.sv */
`timescale 1ns/1ps
`define CHECK(a, b) \
    begin \
        checked++; \
        if ((a) !== (b)) \
        begin \
            failures++; \
            $display("FAIL %0t got %h expected %h", $time, (a), (b)); \
        end \
    end
module test_reservation_report_builder;
    logic               clock = 1'b0;
    logic               resetn = 1'b0;
    logic [11:0]        regAddr = 12'h000;
    logic [31:0]        regWrData = 32'h0;
    logic               regWrite = 1'b0;
    logic               regRead = 1'b0;
    logic [31:0]        regRdData;
    rrb_pkg::rrb_evt_t  resvEvent = '0;
    logic               cmdValid = 1'b0;
    logic               cmdReady;
    rrb_pkg::rrb_cmd_t  cmd = '0;
    logic               descValid, descReady, dataValid, dataReady, cplValid, cplReady;
    rrb_pkg::rrb_desc_t desc;
    rrb_pkg::rrb_data_t dataOut;
    rrb_pkg::rrb_cpl_t  cpl;
    logic               slow = 1'b0;
    logic               clearRec = 1'b1;
    int                 failures = 0;
    int                 checked = 0;
    int                 cycles = 0;
    logic [31:0]        expCounter = 32'h0;
    logic [15:0]        expCount;
    logic [7:0]         expKind, expPersist;

    rrb_builder uut (.clock(clock), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .resvEvent(resvEvent),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd), .descValid(descValid),
        .descReady(descReady), .desc(desc), .dataValid(dataValid), .dataReady(dataReady),
        .dataOut(dataOut), .cplValid(cplValid), .cplReady(cplReady), .cpl(cpl));
    rrb_host_model host (.clock(clock), .resetn(resetn), .slow(slow), .clear(clearRec),
        .descValid(descValid), .descReady(descReady), .desc(desc), .dataValid(dataValid),
        .dataReady(dataReady), .dataOut(dataOut), .cplValid(cplValid), .cplReady(cplReady),
        .cpl(cpl));

    // clock and hang guard
    always #2.5 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // register port accesses, one strobe cycle each
    task automatic wrReg(input logic [11:0] addr, input logic [31:0] data);
        @(posedge clock);
        regWrite  <= 1'b1;
        regAddr   <= addr;
        regWrData <= data;
        @(posedge clock);
        regWrite  <= 1'b0;
    endtask
    task automatic rdExpect(input logic [11:0] addr, input logic [31:0] exp);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= addr;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        `CHECK(regRdData, exp)
    endtask

    // one cycle of reservation command completions
    task automatic pulseEvt(input logic r, input logic rl, input logic [2:0] ra,
                            input logic aq, input logic [2:0] aa);
        @(posedge clock);
        resvEvent <= '{r, rl, ra, aq, aa};
        @(posedge clock);
        resvEvent <= '0;
        expCounter = expCounter + 32'(r) + 32'(rl && ra == 3'h1) + 32'(aq && (aa == 3'h1 || aa == 3'h2));
    endtask

    // entry words as written and as reported
    function automatic logic [31:0] entryWord(int e, int w);
        if (w == 0)
            return {15'h0, e == 0, 16'h0100 + 16'(e)};
        if (w == 1)
            return 32'h0;
        return {4'ha, 4'(w), 24'(e)};
    endfunction
    function automatic logic [31:0] expWord(int i);
        if (i == 0)
            return expCounter;
        if (i == 1)
            return {8'h00, expCount, expKind};
        if (i == 2)
            return {16'h0000, expPersist, 8'h00};
        if (i < 6)
            return 32'h0;
        return entryWord((i - 6) / 6, (i - 6) % 6);
    endfunction

    // issues one report command and waits for its completion
    task automatic runCmd(input logic [15:0] id, input logic [31:0] field);
        int n;
        @(posedge clock);
        clearRec <= 1'b1;
        @(posedge clock);
        clearRec <= 1'b0;
        cmdValid <= 1'b1;
        cmd      <= '{id, field, {8{id}}};
        n = 0;
        @(negedge clock);
        while (cmdReady !== 1'b1 && n < 100)
        begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        cmdValid <= 1'b0;
        n = 0;
        while (host.cplSeen == 0 && n < 3000)
        begin
            @(posedge clock);
            n++;
        end
        @(negedge clock);
    endtask

    task automatic doCase(input logic [15:0] cnt, input logic [7:0] kind, input logic [7:0] pers,
                          input logic [31:0] field, input logic pace, input logic [15:0] id);
        logic [32:0] expLen;
        expCount   = cnt;
        expKind    = kind;
        expPersist = pers;
        slow      <= pace;
        wrReg(rrb_pkg::OFF_CTRL, {16'h0, pers, kind});
        wrReg(rrb_pkg::OFF_REGCOUNT, {16'h0, cnt});
        runCmd(id, field);
        expLen = {1'b0, field} + 33'h1;
        if (expLen > 33'(6 + 6 * int'(cnt)))
            expLen = 33'(6 + 6 * int'(cnt));
        `CHECK(host.descSeen.dwordLen, expLen)
        `CHECK(host.descSeen.bufferPointer, {8{id}})
        `CHECK(host.nWords, int'(expLen))
        `CHECK(host.lastAt, int'(expLen) - 1)
        `CHECK(host.wordsAtCpl, int'(expLen))
        `CHECK(host.cplGot, {id, rrb_pkg::STATUS_SUCCESS})
        for (int i = 0; i < int'(expLen) && i < 64; i++)
            `CHECK(host.words[i], expWord(i))
    endtask

    // main sequence
    initial
    begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        rdExpect(rrb_pkg::OFF_COUNTER, 32'h0);
        rdExpect(rrb_pkg::OFF_CTRL, 32'h0);
        rdExpect(rrb_pkg::OFF_REGCOUNT, 32'h0);
        rdExpect(12'h050, 32'h0);
        pulseEvt(1'b1, 1'b0, 3'h0, 1'b0, 3'h0);
        for (int a = 0; a < 8; a++)
        begin
            pulseEvt(1'b0, 1'b1, 3'(a), 1'b0, 3'h0);
            pulseEvt(1'b0, 1'b0, 3'h0, 1'b1, 3'(a));
        end
        pulseEvt(1'b1, 1'b1, rrb_pkg::RELEASE_CLEAR, 1'b1, rrb_pkg::ACQUIRE_PRE_ABRT);
        rdExpect(rrb_pkg::OFF_COUNTER, 32'h7);
        `CHECK(expCounter, 32'h7)
        for (int e = 0; e < 8; e++)
            for (int w = 0; w < 6; w++)
                wrReg(12'(rrb_pkg::OFF_ENTRIES + e * 32 + w * 4),
                      w == 0 ? entryWord(e, w) | 32'hfffe_0000 : (w == 1 ? 32'hffff_ffff : entryWord(e, w)));
        rdExpect(12'(rrb_pkg::OFF_ENTRIES + 32), entryWord(1, 0));
        rdExpect(12'(rrb_pkg::OFF_ENTRIES + 36), 32'h0);
        wrReg(rrb_pkg::OFF_REGCOUNT, 32'h9);
        rdExpect(rrb_pkg::OFF_REGCOUNT, 32'h8);
        doCase(16'h2, 8'h05, rrb_pkg::PERSIST_KEPT, 32'h0, 1'b0, 16'h1101);
        doCase(16'h2, 8'h05, rrb_pkg::PERSIST_KEPT, 32'h4, 1'b0, 16'h2202);
        doCase(16'h2, 8'h03, rrb_pkg::PERSIST_KEPT, 32'd100, 1'b1, 16'h3303);
        doCase(16'h8, 8'h01, rrb_pkg::PERSIST_KEPT, 32'hffff_ffff, 1'b1, 16'h4404);
        doCase(16'h0, 8'h00, rrb_pkg::PERSIST_CLEARED, 32'h5, 1'b0, 16'h5505);
        rdExpect(rrb_pkg::OFF_STATUS, 32'h0000_0005);
        complete_run();
    end
endmodule
